// ==== shared/phar_defines.vh ====
`ifndef PHAR_DEFINES_VH
`define PHAR_DEFINES_VH
`define PHAR_OFS_PCI_BASE 32'h10004000
`define PHAR_OFS_INT_BASE 32'h10004008
`define PHAR_OFS_VERSION 32'h10004010
`define PHAR_OFS_CFG_ADDR 32'h10004014
`define PHAR_OFS_CFG_DATA 32'h10004018
`define PHAR_OFS_INT_STAT 32'h1000401c
`define PHAR_OFS_INT_MASK 32'h10004020
`define PHAR_OFS_PCI_STAT 32'h10004024
`define PHAR_OFS_PCI_MASK 32'h10004028
`define PHAR_OFS_HOST_CTL 32'h10004030
`define PHAR_OFS_PWR_CONS 32'h10004040
`define PHAR_OFS_PWR_DISS 32'h10004044
`define PHAR_OFS_BRG_CTL 32'h10004050
`define PHAR_OFS_PWR_CTL 32'h10004054
`define PHAR_OFS_SOFT_RST 32'h10004058
`define PHAR_OFS_RETRY_TMR 32'h1000405c
`define PHAR_OFS_CFG_SPACE 32'h10004100
`define PHAR_REG_PAGE 32'h10004000
`define PHAR_BASE_MASK 32'hffc00000
`define PHAR_CFG_ADDR_MASK 32'h80ffffff
// arbitrary value
`define PHAR_VERSION_VAL 32'h00020003
`define PHAR_CFG_EN_BIT 31
`define PHAR_HC_RESET_BIT 0
`define PHAR_HC_ARBMODE_BIT 1
`define PHAR_ST_IRQ 11
`define PHAR_ST_SERR 10
`define PHAR_ST_PERR 9
`define PHAR_ST_INT_READ_BUS_ERROR_FLAG 6
`define PHAR_ST_INT_WRITE_BUS_ERROR_FLAG 5
`define PHAR_ST_DISCARD 4
`define PHAR_ST_READ_TARGET_ABORT_FLAG 3
`define PHAR_ST_WRITE_TARGET_ABORT_FLAG 2
`define PHAR_ST_READ_MASTER_ABORT_FLAG 1
`define PHAR_ST_WRITE_MASTER_ABORT_FLAG 0
`define PHAR_ST_USED_MASK 32'hffff0e7f
`define PHAR_DISCARD_CYCLES 32768
`endif

// ==== core/phar_arbiter.v ====
`timescale 1ns/10ps
`include "phar_defines.vh"
module phar_arbiter (
  input wire I_CLK,
  input wire I_RESETN,
  input wire i_enable,
  input wire i_rotating,
  input wire [4:0] i_req,
  input wire i_bus_idle,
  output wire [4:0] o_gnt
);
  // slot 0 is the bridge itself, slots 1..4 external masters
  reg [4:0] gnt_reg;
  reg [4:0] gnt_next;
  reg [2:0] last_reg;
  reg [2:0] last_next;
  reg [1:0] grp_ptr_reg;
  reg [1:0] grp_ptr_next;
  reg own_turn_reg;
  reg own_turn_next;
  reg found;
  reg [2:0] idx;
  reg [3:0] sum;
  reg [1:0] gidx;
  integer k;

  assign o_gnt = gnt_reg;

  always @* begin
    gnt_next = gnt_reg;
    last_next = last_reg;
    grp_ptr_next = grp_ptr_reg;
    own_turn_next = own_turn_reg;
    found = 1'b0;
    idx = 3'h0;
    sum = 4'h0;
    gidx = 2'h0;
    if (!i_enable) begin
      gnt_next = 5'h00;
    end else if (i_bus_idle) begin // R27
      if (i_rotating) begin
        for (k = 1; k <= 5; k = k + 1) begin
          // four-bit sum, a three-bit one wraps before the modulo-5 fold
          sum = {1'b0, last_reg} + {1'b0, k[2:0]};
          idx = (sum >= 4'h5) ? sum[2:0] - 3'h5 : sum[2:0];
          if (!found && i_req[idx]) begin // R3
            found = 1'b1;
            last_next = idx;
          end
        end
        gnt_next = 5'h01 << last_next; // R4 R27
      end else begin
        found = 1'b0;
        for (k = 1; k <= 4; k = k + 1) begin
          gidx = grp_ptr_reg + k[1:0];
          if (!found && i_req[{1'b0, gidx} + 3'h1]) begin
            found = 1'b1;
            grp_ptr_next = gidx;
          end
        end
        if (i_req[0] && (own_turn_reg || !found)) begin // R1
          gnt_next = 5'h01;
          grp_ptr_next = grp_ptr_reg;
          own_turn_next = 1'b0;
        end else if (found) begin
          gnt_next = 5'h02 << grp_ptr_next; // R1
          own_turn_next = 1'b1;
        end else begin
          gnt_next = 5'h01; // R2
        end
        last_next = 3'h0;
      end
    end
  end

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gnt_reg <= 5'h00;
      last_reg <= 3'h0;
      grp_ptr_reg <= 2'h3;
      own_turn_reg <= 1'b1;
    end else begin
      gnt_reg <= gnt_next;
      last_reg <= last_next;
      grp_ptr_reg <= grp_ptr_next;
      own_turn_reg <= own_turn_next;
    end
  end
endmodule

// ==== core/phar_top.v ====
`timescale 1ns/10ps
`include "phar_defines.vh"
// Functional notes
// R1 - alternate bridge and external group; rotate group
// R2 - alternating idle: park bus on bridge
// R3 - rotating: even rotation over all masters
// R4 - rotating idle: park on last owner
// R5 - bus reset follows control bit
// R6 - interrupt input level sets bit 11
// R7 - system error edge sets bit 10
// R8 - burst register access: error flag, nmi
// R9 - reserved read: bus error, data error
// R10 - reserved write: bus error, data dropped
// R11 - read-only writes ignored; width limits
// R12 - only the cpu reaches registers
// R13 - outbound address upper bits from pci base
// R14 - inbound address upper bits from internal base
// R15 - fixed version register, major/minor halves
// R16 - config data access runs config cycle
// R17 - config address field layout, 30:24 zero
// R18 - cycle type 00 type0, 01 type1
// R19 - status bits interrupt cpu when unmasked
// R20 - read clears status; pci sets user bits
// R21 - delayed read timeout discards, sets bit 4
// R22 - abort, bus error, parity status bits
// R23 - arbiter for four masters, host mode only
// R24 - control bit picks arbitration mode
// R25 - config disabled: writes ignored, reads zero
// R26 - type0 idsel one-hot from device number
// R27 - one grant at a time, per transaction
module phar_top (
  input wire I_CLK,
  input wire I_RESETN,
  input wire I_HOST_OR_NIC_SELECT,
  input wire I_ARBITER_ENABLE_INPUT,
  input wire I_REG_SEL,
  input wire I_REG_WR,
  input wire I_REG_BURST,
  input wire I_REG_FROM_CPU,
  input wire [31:0] I_REG_ADDR,
  input wire [3:0] I_REG_BE,
  input wire [31:0] I_REG_WDATA,
  output reg [31:0] O_REG_RDATA,
  output reg O_REG_ACK,
  output reg O_SYSTEM_COMMAND_BUS_ERR,
  output wire O_REGISTER_BURST_ERROR_FLAG,
  output wire O_BUS_ERROR_FLAG,
  output wire O_NMI,
  output wire O_CPU_IRQ,
  input wire I_PCI_USER_WR,
  input wire [15:0] I_PCI_USER_DATA,
  input wire I_PCI_IRQ,
  input wire I_SERR_N,
  input wire I_EV_PERR,
  input wire I_EV_RD_TABORT,
  input wire I_EV_WR_TABORT,
  input wire I_EV_RD_MABORT,
  input wire I_EV_WR_MABORT,
  input wire I_EV_RD_IBERR,
  input wire I_EV_WR_IBERR,
  input wire I_DLY_READ_PENDING,
  input wire I_DLY_READ_REPEAT,
  output reg O_DLY_READ_DISCARD,
  input wire [31:0] I_OUT_ADDR,
  output wire [31:0] O_OUT_PCI_ADDR,
  input wire [31:0] I_IN_PCI_ADDR,
  output wire [31:0] O_IN_INT_ADDR,
  output reg O_CFG_START,
  output reg O_CFG_WRITE,
  output reg [31:0] O_CFG_ADDR_PHASE,
  output reg [31:0] O_CFG_WDATA,
  input wire I_CFG_DONE,
  input wire [31:0] I_CFG_RDATA,
  output wire O_PCI_RESET_N,
  input wire [4:0] I_REQ_N,
  input wire I_BUS_IDLE,
  output wire [4:0] O_GNT_N,
  output wire O_PARK_DRIVE
);
  parameter DISCARD_CYCLES = `PHAR_DISCARD_CYCLES;

  reg [31:0] pci_base_reg;
  reg [31:0] int_base_reg;
  reg [31:0] cfg_addr_reg;
  reg [31:0] cfg_data_reg;
  reg [31:0] stat_reg;
  reg [31:0] stat_next;
  reg [31:0] mask_reg;
  reg [31:0] pci_stat_reg;
  reg [31:0] pci_mask_reg;
  reg [31:0] host_ctl_reg;
  reg [31:0] pwr_cons_reg;
  reg [31:0] pwr_diss_reg;
  reg [31:0] brg_ctl_reg;
  reg [31:0] pwr_ctl_reg;
  reg [31:0] retry_reg;
  reg burst_err_reg;
  reg bus_err_reg;
  reg serr_n_dly_reg;
  reg cfg_busy_reg;
  reg [15:0] dly_cnt_reg;
  reg [31:0] rd_val;
  reg rd_hit;
  reg wr_hit;
  reg word_only;
  reg [31:0] bmask;
  reg [31:0] idsel;
  wire host_mode;
  wire access;
  wire is_cfg_data;
  wire cfg_run;
  wire [4:0] gnt;
  wire [31:0] wmerge_base;

  assign host_mode = ~I_HOST_OR_NIC_SELECT;
  assign access = I_REG_SEL & I_REG_FROM_CPU & ~I_REG_BURST; // R12 R8
  assign is_cfg_data = I_REG_ADDR == `PHAR_OFS_CFG_DATA;
  assign cfg_run = access & is_cfg_data & cfg_addr_reg[`PHAR_CFG_EN_BIT] & host_mode; // R16

  ////////////////////////////////////////////////////////////////////////////
  // address translation

  assign O_OUT_PCI_ADDR = (pci_base_reg & `PHAR_BASE_MASK) |
                          (I_OUT_ADDR & ~`PHAR_BASE_MASK); // R13
  assign O_IN_INT_ADDR = (int_base_reg & `PHAR_BASE_MASK) |
                         (I_IN_PCI_ADDR & ~`PHAR_BASE_MASK); // R14
  assign wmerge_base = I_REG_WDATA & `PHAR_BASE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  always @* begin
    bmask = {{8{I_REG_BE[3]}}, {8{I_REG_BE[2]}}, {8{I_REG_BE[1]}}, {8{I_REG_BE[0]}}};
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    word_only = 1'b0;
    rd_val = 32'h00000000;
    case (I_REG_ADDR)
      `PHAR_OFS_PCI_BASE: rd_val = pci_base_reg;
      `PHAR_OFS_INT_BASE: rd_val = int_base_reg;
      `PHAR_OFS_VERSION: rd_val = `PHAR_VERSION_VAL; // R15
      `PHAR_OFS_CFG_ADDR: rd_val = cfg_addr_reg & `PHAR_CFG_ADDR_MASK; // R17
      `PHAR_OFS_CFG_DATA: rd_val = cfg_data_reg;
      `PHAR_OFS_INT_STAT: begin
        rd_val = stat_reg;
        word_only = 1'b1;
      end
      `PHAR_OFS_INT_MASK: rd_val = mask_reg;
      `PHAR_OFS_PCI_STAT: begin
        rd_val = pci_stat_reg;
        word_only = 1'b1;
      end
      `PHAR_OFS_PCI_MASK: rd_val = pci_mask_reg;
      `PHAR_OFS_HOST_CTL: rd_val = host_ctl_reg;
      `PHAR_OFS_PWR_CONS: rd_val = pwr_cons_reg;
      `PHAR_OFS_PWR_DISS: rd_val = pwr_diss_reg;
      `PHAR_OFS_BRG_CTL: rd_val = brg_ctl_reg;
      `PHAR_OFS_PWR_CTL: rd_val = pwr_ctl_reg;
      `PHAR_OFS_SOFT_RST: begin
        rd_hit = 1'b0;
        word_only = 1'b1;
      end
      `PHAR_OFS_RETRY_TMR: rd_val = retry_reg;
      default: begin
        // config space mirror lives in the pci data path, reads zero here
        rd_hit = (I_REG_ADDR[31:8] == `PHAR_OFS_CFG_SPACE >> 8) && (I_REG_ADDR[1:0] == 2'h0);
        wr_hit = rd_hit;
      end
    endcase
    if (word_only && I_REG_BE != 4'hf) begin // R11
      wr_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // type0 idsel decode

  always @* begin
    idsel = 32'h00000000;
    if (!cfg_addr_reg[15]) begin // R26
      idsel[{1'b1, cfg_addr_reg[14:11]}] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status

  always @* begin
    stat_next = stat_reg;
    if (access && !I_REG_WR && I_REG_ADDR == `PHAR_OFS_INT_STAT) begin
      stat_next = 32'h00000000; // R20
    end
    // sets applied after clear so a same-cycle event survives
    if (I_PCI_USER_WR) begin
      stat_next[31:16] = stat_next[31:16] | I_PCI_USER_DATA; // R20
    end
    stat_next[`PHAR_ST_IRQ] = stat_next[`PHAR_ST_IRQ] | (I_PCI_IRQ & host_mode); // R6
    stat_next[`PHAR_ST_SERR] = stat_next[`PHAR_ST_SERR] |
                               (serr_n_dly_reg & ~I_SERR_N & host_mode); // R7
    stat_next[`PHAR_ST_PERR] = stat_next[`PHAR_ST_PERR] | I_EV_PERR; // R22
    stat_next[`PHAR_ST_INT_READ_BUS_ERROR_FLAG] = stat_next[`PHAR_ST_INT_READ_BUS_ERROR_FLAG] | I_EV_RD_IBERR; // R22
    stat_next[`PHAR_ST_INT_WRITE_BUS_ERROR_FLAG] = stat_next[`PHAR_ST_INT_WRITE_BUS_ERROR_FLAG] | I_EV_WR_IBERR; // R22
    stat_next[`PHAR_ST_READ_TARGET_ABORT_FLAG] = stat_next[`PHAR_ST_READ_TARGET_ABORT_FLAG] | I_EV_RD_TABORT; // R22
    stat_next[`PHAR_ST_WRITE_TARGET_ABORT_FLAG] = stat_next[`PHAR_ST_WRITE_TARGET_ABORT_FLAG] | I_EV_WR_TABORT; // R22
    stat_next[`PHAR_ST_READ_MASTER_ABORT_FLAG] = stat_next[`PHAR_ST_READ_MASTER_ABORT_FLAG] | I_EV_RD_MABORT; // R22
    stat_next[`PHAR_ST_WRITE_MASTER_ABORT_FLAG] = stat_next[`PHAR_ST_WRITE_MASTER_ABORT_FLAG] | I_EV_WR_MABORT; // R22
    if (dly_cnt_reg == DISCARD_CYCLES - 1) begin
      stat_next[`PHAR_ST_DISCARD] = 1'b1; // R21
    end
    stat_next = stat_next & `PHAR_ST_USED_MASK;
  end

  assign O_CPU_IRQ = |(stat_reg & mask_reg); // R19 R6 R7
  assign O_REGISTER_BURST_ERROR_FLAG = burst_err_reg;
  assign O_BUS_ERROR_FLAG = bus_err_reg;
  assign O_NMI = burst_err_reg; // R8
  assign O_PCI_RESET_N = ~(host_mode & host_ctl_reg[`PHAR_HC_RESET_BIT]); // R5
  assign O_GNT_N = ~gnt;
  assign O_PARK_DRIVE = gnt[0] & ~host_ctl_reg[`PHAR_HC_ARBMODE_BIT] & (&I_REQ_N); // R2

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pci_base_reg <= 32'h00000000;
      int_base_reg <= 32'h00000000;
      cfg_addr_reg <= 32'h00000000;
      cfg_data_reg <= 32'h00000000;
      stat_reg <= 32'h00000000;
      mask_reg <= 32'h00000000;
      pci_stat_reg <= 32'h00000000;
      pci_mask_reg <= 32'h00000000;
      host_ctl_reg <= 32'h00000000;
      pwr_cons_reg <= 32'h00000000;
      pwr_diss_reg <= 32'h00000000;
      brg_ctl_reg <= 32'h00000000;
      pwr_ctl_reg <= 32'h00000000;
      retry_reg <= 32'h00000000;
      burst_err_reg <= 1'b0;
      bus_err_reg <= 1'b0;
      serr_n_dly_reg <= 1'b1;
      cfg_busy_reg <= 1'b0;
      dly_cnt_reg <= 16'h0000;
      O_DLY_READ_DISCARD <= 1'b0;
      O_REG_RDATA <= 32'h00000000;
      O_REG_ACK <= 1'b0;
      O_SYSTEM_COMMAND_BUS_ERR <= 1'b0;
      O_CFG_START <= 1'b0;
      O_CFG_WRITE <= 1'b0;
      O_CFG_ADDR_PHASE <= 32'h00000000;
      O_CFG_WDATA <= 32'h00000000;
    end else begin
      stat_reg <= stat_next;
      serr_n_dly_reg <= I_SERR_N;
      O_REG_ACK <= 1'b0;
      O_SYSTEM_COMMAND_BUS_ERR <= 1'b0;
      O_CFG_START <= 1'b0;
      O_DLY_READ_DISCARD <= 1'b0;
      if (I_REG_SEL && I_REG_FROM_CPU && I_REG_BURST) begin
        burst_err_reg <= 1'b1; // R8
        O_REG_ACK <= 1'b1;
      end
      // delayed read timer restarts on repeat, clears when idle
      if (!I_DLY_READ_PENDING || I_DLY_READ_REPEAT) begin
        dly_cnt_reg <= 16'h0000;
      end else if (dly_cnt_reg == DISCARD_CYCLES - 1) begin
        dly_cnt_reg <= 16'h0000;
        O_DLY_READ_DISCARD <= 1'b1; // R21
      end else begin
        dly_cnt_reg <= dly_cnt_reg + 16'h0001;
      end
      if (cfg_busy_reg && I_CFG_DONE) begin
        cfg_busy_reg <= 1'b0;
        O_REG_ACK <= 1'b1;
        if (!O_CFG_WRITE) begin
          cfg_data_reg <= I_CFG_RDATA;
          O_REG_RDATA <= I_CFG_RDATA;
        end
      end else if (access && !cfg_busy_reg && cfg_run) begin
        // ack is held back until the pci cycle completes
        cfg_busy_reg <= 1'b1;
        O_CFG_START <= 1'b1; // R16
        O_CFG_WRITE <= I_REG_WR;
        O_CFG_WDATA <= I_REG_WDATA;
        if (cfg_addr_reg[1:0] == 2'h0) begin // R18
          O_CFG_ADDR_PHASE <= idsel | {21'h000000, cfg_addr_reg[10:2], 2'h0};
        end else begin
          O_CFG_ADDR_PHASE <= {8'h00, cfg_addr_reg[23:2], 2'h1}; // R18
        end
      end else if (access && !cfg_busy_reg) begin
        O_REG_ACK <= 1'b1;
        if (!I_REG_WR) begin
          O_REG_RDATA <= (rd_hit && !is_cfg_data) ? rd_val : 32'h00000000; // R25
          if (!rd_hit) begin
            bus_err_reg <= 1'b1; // R9
            O_SYSTEM_COMMAND_BUS_ERR <= 1'b1; // R9
          end
        end else if (!wr_hit) begin
          if (I_REG_ADDR != `PHAR_OFS_SOFT_RST && !(I_REG_ADDR[31:8] == `PHAR_REG_PAGE >> 8 &&
              I_REG_BE != 4'hf && (I_REG_ADDR == `PHAR_OFS_INT_STAT ||
              I_REG_ADDR == `PHAR_OFS_PCI_STAT))) begin
            bus_err_reg <= 1'b1; // R10
          end
        end else begin
          case (I_REG_ADDR) // R11
            `PHAR_OFS_PCI_BASE: pci_base_reg <= (pci_base_reg & ~(bmask & `PHAR_BASE_MASK)) |
                                                (wmerge_base & bmask); // R13
            `PHAR_OFS_INT_BASE: int_base_reg <= (int_base_reg & ~(bmask & `PHAR_BASE_MASK)) |
                                                (wmerge_base & bmask); // R14
            `PHAR_OFS_CFG_ADDR: cfg_addr_reg <= ((cfg_addr_reg & ~bmask) |
                                  (I_REG_WDATA & bmask)) & `PHAR_CFG_ADDR_MASK; // R17
            `PHAR_OFS_INT_MASK: mask_reg <= ((mask_reg & ~bmask) | (I_REG_WDATA & bmask)) &
                                            `PHAR_ST_USED_MASK;
            `PHAR_OFS_PCI_STAT: pci_stat_reg <= I_REG_WDATA;
            `PHAR_OFS_PCI_MASK: pci_mask_reg <= (pci_mask_reg & ~bmask) | (I_REG_WDATA & bmask);
            `PHAR_OFS_HOST_CTL: host_ctl_reg <= (host_ctl_reg & ~bmask) |
                                                (I_REG_WDATA & bmask); // R5 R24
            `PHAR_OFS_PWR_CONS: pwr_cons_reg <= (pwr_cons_reg & ~bmask) | (I_REG_WDATA & bmask);
            `PHAR_OFS_PWR_DISS: pwr_diss_reg <= (pwr_diss_reg & ~bmask) | (I_REG_WDATA & bmask);
            `PHAR_OFS_BRG_CTL: brg_ctl_reg <= (brg_ctl_reg & ~bmask) | (I_REG_WDATA & bmask);
            `PHAR_OFS_PWR_CTL: pwr_ctl_reg <= (pwr_ctl_reg & ~bmask) | (I_REG_WDATA & bmask);
            `PHAR_OFS_RETRY_TMR: retry_reg <= (retry_reg & ~bmask) | (I_REG_WDATA & bmask);
            default: begin
              // read-only or config-disabled targets: data dropped, no error
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbiter

  phar_arbiter u_arb (
    .I_CLK(I_CLK),
    .I_RESETN(I_RESETN),
    .i_enable(host_mode & I_ARBITER_ENABLE_INPUT), // R23
    .i_rotating(host_ctl_reg[`PHAR_HC_ARBMODE_BIT]), // R24
    .i_req(~I_REQ_N),
    .i_bus_idle(I_BUS_IDLE),
    .o_gnt(gnt)
  );
endmodule

// ==== bench/phar_asserts.sv ====
`timescale 1ns/10ps
module phar_asserts (
  input wire I_CLK,
  input wire I_RESETN,
  input wire I_HOST_OR_NIC_SELECT,
  input wire I_ARBITER_ENABLE_INPUT,
  input wire I_REG_SEL,
  input wire I_REG_WR,
  input wire I_REG_BURST,
  input wire I_REG_FROM_CPU,
  input wire [31:0] I_REG_ADDR,
  input wire O_REG_ACK,
  input wire O_SYSTEM_COMMAND_BUS_ERR,
  input wire O_REGISTER_BURST_ERROR_FLAG,
  input wire O_BUS_ERROR_FLAG,
  input wire O_NMI,
  input wire I_CFG_DONE,
  input wire O_CFG_START,
  input wire [31:0] I_OUT_ADDR,
  input wire [31:0] O_OUT_PCI_ADDR,
  input wire O_PCI_RESET_N,
  input wire [4:0] O_GNT_N
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  wire acc = I_REG_SEL && I_REG_FROM_CPU;
  ////////////////////////////////////////////////////////////////////////
  property p_nic_rst; I_HOST_OR_NIC_SELECT |-> O_PCI_RESET_N; endproperty
  a_nic_rst: assert property (p_nic_rst) else $error("bus reset in nic mode");
  property p_gnt_off; !I_ARBITER_ENABLE_INPUT || I_HOST_OR_NIC_SELECT |=> &O_GNT_N; endproperty
  a_gnt_off: assert property (p_gnt_off) else $error("grant while disabled");
  property p_gnt_one; $onehot0(~O_GNT_N); endproperty
  a_gnt_one: assert property (p_gnt_one) else $error("two grants");
  property p_nocpu; I_REG_SEL && !I_REG_FROM_CPU && !I_CFG_DONE |=> !O_REG_ACK; endproperty
  a_nocpu: assert property (p_nocpu) else $error("non-cpu access acked");
  property p_burst; acc && I_REG_BURST |=> O_REG_ACK && O_NMI && O_REGISTER_BURST_ERROR_FLAG;
  endproperty
  a_burst: assert property (p_burst) else $error("burst not flagged");
  property p_rsv_rd;
    acc && !I_REG_WR && !I_REG_BURST && I_REG_ADDR == 32'h10004004
    |=> O_REG_ACK && O_SYSTEM_COMMAND_BUS_ERR && O_BUS_ERROR_FLAG;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved read");
  property p_err_ack; O_SYSTEM_COMMAND_BUS_ERR |-> O_REG_ACK && !$past(I_REG_WR); endproperty
  a_err_ack: assert property (p_err_ack) else $error("data error off a read");
  property p_bus_rise; $rose(O_BUS_ERROR_FLAG) |-> $past(acc); endproperty
  a_bus_rise: assert property (p_bus_rise) else $error("bus error without access");
  property p_cfg_ack; I_CFG_DONE |=> O_REG_ACK; endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("config ack late");
  property p_start; O_CFG_START |=> !O_CFG_START; endproperty
  a_start: assert property (p_start) else $error("config start held");
  property p_out; O_OUT_PCI_ADDR[21:0] == I_OUT_ADDR[21:0]; endproperty
  a_out: assert property (p_out) else $error("outbound low bits");
endmodule
bind phar_top phar_asserts u_chk (.*);

// ==== bench/phar_cfg_target.sv ====
`timescale 1ns/10ps
module phar_cfg_target #(
  parameter [31:0] RDATA = 32'h0
) (
  input wire i_clk,
  input wire i_start,
  input wire [7:0] i_delay,
  output reg o_done,
  output reg [31:0] o_rdata
);
  initial begin
    o_done = 1'b0;
    o_rdata = 32'h0;
  end
  // delay set by the bench so both prompt and slow targets are seen
  always @(posedge i_clk) begin
    if (i_start) begin
      repeat (i_delay) @(posedge i_clk);
      o_rdata <= RDATA;
      o_done <= 1'b1;
      @(posedge i_clk);
      o_done <= 1'b0;
      // released data must not look valid afterwards
      o_rdata <= ~RDATA;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`include "phar_defines.vh"
module tb_top;
  localparam [31:0] ST = `PHAR_OFS_INT_STAT;
  localparam [31:0] MK = `PHAR_OFS_INT_MASK;
  localparam [31:0] CA = `PHAR_OFS_CFG_ADDR;
  localparam [31:0] CD = `PHAR_OFS_CFG_DATA;
  reg clk = 0, rstn = 0, nic = 0, arben = 1, sel = 0, wr = 0, bst = 0, cpu = 1;
  reg uwr = 0, irq = 0, serr_n = 1, pend = 0, rep = 0, idle = 1, lerr = 0, cap_w = 0;
  reg [6:0] ev = 0;
  reg [15:0] ud = 0;
  reg [4:0] reqn = 5'h1f;
  reg [7:0] dly = 0;
  reg [3:0] be = 4'hf;
  reg [31:0] adr = 0, wd = 0, oa = 0, ia = 0, cap = 0, cap_d = 0;
  wire [31:0] rd, oa_o, ia_o, cph, cwd, crd;
  wire [4:0] gnt_n;
  wire ack, err, bfl, rfl, nmi, cirq, disc, cst, cw, done, prst_n, park;
  integer miscompares = 0, n_checks = 0, cyc = 0, n_st = 0, n_disc = 0;
  phar_top #(.DISCARD_CYCLES(16)) i_dut (
    .I_CLK(clk), .I_RESETN(rstn), .I_HOST_OR_NIC_SELECT(nic),
    .I_ARBITER_ENABLE_INPUT(arben), .I_REG_SEL(sel), .I_REG_WR(wr), .I_REG_BURST(bst),
    .I_REG_FROM_CPU(cpu), .I_REG_ADDR(adr), .I_REG_BE(be), .I_REG_WDATA(wd),
    .O_REG_RDATA(rd), .O_REG_ACK(ack), .O_SYSTEM_COMMAND_BUS_ERR(err),
    .O_REGISTER_BURST_ERROR_FLAG(rfl), .O_BUS_ERROR_FLAG(bfl), .O_NMI(nmi),
    .O_CPU_IRQ(cirq), .I_PCI_USER_WR(uwr), .I_PCI_USER_DATA(ud), .I_PCI_IRQ(irq),
    .I_SERR_N(serr_n), .I_EV_PERR(ev[6]), .I_EV_RD_TABORT(ev[3]), .I_EV_WR_TABORT(ev[2]),
    .I_EV_RD_MABORT(ev[1]), .I_EV_WR_MABORT(ev[0]), .I_EV_RD_IBERR(ev[5]),
    .I_EV_WR_IBERR(ev[4]), .I_DLY_READ_PENDING(pend), .I_DLY_READ_REPEAT(rep),
    .O_DLY_READ_DISCARD(disc), .I_OUT_ADDR(oa), .O_OUT_PCI_ADDR(oa_o),
    .I_IN_PCI_ADDR(ia), .O_IN_INT_ADDR(ia_o), .O_CFG_START(cst), .O_CFG_WRITE(cw),
    .O_CFG_ADDR_PHASE(cph), .O_CFG_WDATA(cwd), .I_CFG_DONE(done), .I_CFG_RDATA(crd),
    .O_PCI_RESET_N(prst_n), .I_REQ_N(reqn), .I_BUS_IDLE(idle), .O_GNT_N(gnt_n),
    .O_PARK_DRIVE(park));
  phar_cfg_target #(.RDATA(32'hc0ffee11)) i_tgt (
    .i_clk(clk), .i_start(cst), .i_delay(dly), .o_done(done), .o_rdata(crd));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cst) begin
      n_st <= n_st + 1;
      cap <= cph;
      cap_d <= cwd;
      cap_w <= cw;
    end
    if (disc)
      n_disc <= n_disc + 1;
    // hang guard, well above the few hundred cycles the run needs
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task cmp(input [8*8:1] nm, input [31:0] x, input [31:0] y);
    begin
      n_checks = n_checks + 1;
      if (y !== x) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s exp %h got %h", nm, x, y);
      end
    end
  endtask
  task automatic acc(input w, input [31:0] a, input [31:0] d, input b, input c,
                     output [31:0] q, output g);
    integer k;
    begin
      @(negedge clk);
      wr = w;
      adr = a;
      wd = d;
      bst = b;
      cpu = c;
      sel = 1;
      @(negedge clk);
      sel = 0;
      g = 0;
      for (k = 0; k < 30 && !g; k = k + 1) begin
        if (ack === 1'b1) begin
          g = 1;
          lerr = err;
        end else
          @(negedge clk);
      end
      q = rd;
      cpu = 1;
      bst = 0;
    end
  endtask
  task automatic wrr(input [31:0] a, input [31:0] d);
    reg [31:0] q;
    reg g;
    acc(1, a, d, 0, 1, q, g);
  endtask
  task automatic chk(input [8*8:1] nm, input [31:0] a, input [31:0] x);
    reg [31:0] q;
    reg g;
    begin
      acc(0, a, 0, 0, 1, q, g);
      cmp(nm, x, q);
    end
  endtask
  task automatic txn(output [4:0] g);
    begin
      idle = 1;
      @(negedge clk);
      g = gnt_n;
      idle = 0;
      @(negedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      oa = 32'h00123456;
      ia = 32'hffffffff;
      chk("base", `PHAR_OFS_PCI_BASE, 32'h0);
      chk("ver", `PHAR_OFS_VERSION, `PHAR_VERSION_VAL);
      wrr(`PHAR_OFS_PCI_BASE, 32'hffffffff);
      chk("base", `PHAR_OFS_PCI_BASE, 32'hffc00000);
      wrr(`PHAR_OFS_INT_BASE, 32'h5a5a5a5a);
      chk("ibase", `PHAR_OFS_INT_BASE, 32'h5a400000);
      cmp("oaddr", 32'hffd23456, oa_o);
      cmp("iaddr", 32'h5a7fffff, ia_o);
      wrr(`PHAR_OFS_VERSION, 32'h0);
      chk("ver", `PHAR_OFS_VERSION, `PHAR_VERSION_VAL);
      wrr(CA, 32'hffffffff);
      chk("caddr", CA, 32'h80ffffff);
    end
  endtask
  task t_cfg;
    reg [31:0] ca [0:2];
    reg [31:0] ph [0:2];
    integer i, s;
    begin
      // bus number set on type 0 must not leak into the address phase
      ca[0] = 32'h80071a14;
      ph[0] = 32'h00080214;
      ca[1] = 32'h80071a15;
      ph[1] = 32'h00071a15;
      ca[2] = 32'h80078214;
      ph[2] = 32'h00000214;
      for (i = 0; i < 3; i = i + 1) begin
        dly = 8'h4 * i[7:0];
        wrr(CA, ca[i]);
        s = n_st;
        wrr(CD, 32'h1234abcd);
        cmp("starts", s + 1, n_st);
        cmp("phase", ph[i], cap);
        cmp("cwdata", 32'h1234abcd, cap_d);
        cmp("cwr", 1, cap_w);
        chk("cread", CD, 32'hc0ffee11);
        cmp("cwr", 0, cap_w);
      end
      wrr(CA, 32'h00071a14);
      s = n_st;
      wrr(CD, 32'hffffffff);
      chk("cread", CD, 32'h0);
      cmp("starts", s, n_st);
    end
  endtask
  task t_stat;
    reg [31:0] q;
    integer i;
    integer bt [0:6];
    begin
      bt = '{0, 1, 2, 3, 5, 6, 9};
      for (i = 0; i < 7; i = i + 1) begin
        ev[i] = 1;
        @(negedge clk);
        ev = 0;
        chk("stat", ST, 32'h1 << bt[i]);
        cmp("irq", 0, cirq);
      end
      ud = 16'h8001;
      uwr = 1;
      @(negedge clk);
      uwr = 0;
      chk("stat", ST, 32'h80010000);
      chk("stat", ST, 32'h0);
      wrr(MK, 32'h00000c00);
      irq = 1;
      repeat (3) @(negedge clk);
      cmp("irq", 1, cirq);
      chk("stat", ST, 32'h800);
      chk("stat", ST, 32'h800);
      irq = 0;
      chk("stat", ST, 32'h800);
      chk("stat", ST, 32'h0);
      cmp("irq", 0, cirq);
      serr_n = 0;
      repeat (3) @(negedge clk);
      cmp("irq", 1, cirq);
      chk("stat", ST, 32'h400);
      chk("stat", ST, 32'h0);
      serr_n = 1;
      pend = 1;
      for (i = 0; i < 6; i = i + 1) begin
        repeat (8) @(negedge clk);
        rep = 1;
        @(negedge clk);
        rep = 0;
      end
      cmp("discard", 0, n_disc);
      repeat (20) @(negedge clk);
      pend = 0;
      cmp("discard", 1, n_disc);
      chk("stat", ST, 32'h10);
    end
  endtask
  task t_err;
    reg [31:0] q;
    reg g;
    begin
      acc(1, MK, 32'hffffffff, 0, 0, q, g);
      cmp("ack", 0, g);
      chk("mask", MK, 32'hc00);
      acc(1, MK, 32'h0, 1, 1, q, g);
      cmp("nmi", 1, nmi);
      chk("mask", MK, 32'hc00);
      cmp("buserr", 0, bfl);
      be = 4'h3;
      wrr(`PHAR_OFS_PCI_STAT, 32'h1);
      wrr(MK, 32'hffffffff);
      be = 4'hf;
      chk("pstat", `PHAR_OFS_PCI_STAT, 32'h0);
      chk("mask", MK, 32'he7f);
      cmp("buserr", 0, bfl);
      acc(1, 32'h1000400c, 32'h1, 0, 1, q, g);
      cmp("derr", 0, lerr);
      cmp("buserr", 1, bfl);
      acc(0, 32'h10004004, 0, 0, 1, q, g);
      cmp("rdata", 0, q);
      cmp("derr", 1, lerr);
      cmp("buserr", 1, bfl);
    end
  endtask
  task t_arb;
    reg [4:0] g, p, seen;
    integer i;
    begin
      wrr(`PHAR_OFS_HOST_CTL, 32'h1);
      cmp("rst", 0, prst_n);
      wrr(`PHAR_OFS_HOST_CTL, 32'h0);
      cmp("rst", 1, prst_n);
      txn(g);
      cmp("park", 5'h1e, g);
      cmp("drive", 1, park);
      reqn = 5'h00;
      seen = 0;
      txn(p);
      for (i = 0; i < 8; i = i + 1) begin
        txn(g);
        cmp("alt", !p[0], g[0]);
        seen = seen | ~g;
        p = g;
      end
      cmp("group", 5'h1f, seen);
      wrr(`PHAR_OFS_HOST_CTL, 32'h2);
      seen = 0;
      for (i = 0; i < 5; i = i + 1) begin
        txn(g);
        seen = seen | ~g;
      end
      cmp("rotate", 5'h1f, seen);
      reqn = 5'h1b;
      txn(g);
      reqn = 5'h1f;
      txn(g);
      cmp("lastown", 5'h1b, g);
      arben = 0;
      txn(g);
      cmp("off", 5'h1f, g);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1;
    t_regs;
    t_cfg;
    t_stat;
    t_err;
    t_arb;
    final_report;
  end
endmodule
